// ---- slqs_top.sv ----
// quick setup register and the link control fields it overwrites
// Operation
// - quick setup register always reads back zero
// - register only overwrites other link fields
// - code 0x00 leaves link fields unchanged
// - code 0x02 loads two-lane generic preset
// - code 0x04 loads four-lane generic preset
// - code 0x06 loads six-lane generic preset
// - code 0x08 loads eight-lane generic preset
// - undefined codes leave link fields unchanged
`timescale 1ns/1ps
module slqs_top
  import slqs_pkg::*;
#(
  parameter int unsigned ADDR_W = slqs_pkg::ADDR_W_DEF
)
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  output slqs_pkg::slqs_cfg_t      link_cfg
);

  import slqs_pkg::*;

  generate
    if (ADDR_W < 7 || ADDR_W > 13) begin : g_bad_width
      $error("slqs_top: ADDR_W must lie between 7 and 13");
    end
    // every link field must fit in one register byte
    if (MODE_W > DATA_W || LANES_W > DATA_W || PARM_W > DATA_W) begin : g_bad_field
      $error("slqs_top: a link field is wider than the data byte");
    end
  endgenerate

  slqs_cfg_t    cfg_q;
  slqs_cfg_t    cfg_d;
  slqs_cfg_t    preset_cfg;
  logic         preset_hit;
  logic [7:0]   rdata_q;
  logic [7:0]   rdata_d;
  logic [12:0]  addr_full;
  logic         sel_quick;
  logic         sel_mode;
  logic         sel_lanes;
  logic         sel_parm_a;
  logic         sel_parm_b;

  // zero-extend so the decode compares against the full offsets
  assign addr_full  = 13'(reg_addr);
  assign sel_quick  = (addr_full == OFS_QUICK_SETUP);
  assign sel_mode   = (addr_full == OFS_LINK_MODE);
  assign sel_lanes  = (addr_full == OFS_LANE_COUNT);
  assign sel_parm_a = (addr_full == OFS_LINK_PARM_A);
  assign sel_parm_b = (addr_full == OFS_LINK_PARM_B);

  slqs_preset u_preset (
    .code (reg_wdata),
    .hit  (preset_hit),
    .cfg  (preset_cfg)
  );

  // the quick setup code is never stored: a write acts once and the
  // register falls back to its idle value at once
  always_comb begin
    cfg_d = cfg_q;
    if (reg_wr) begin
      if (sel_quick) begin
        if (preset_hit) begin
          cfg_d = preset_cfg;
        end
        // keep, reserved and unknown codes fall through untouched
      end else if (sel_mode) begin
        cfg_d.mode = reg_wdata[FIELD_LSB +: MODE_W];
      end else if (sel_lanes) begin
        cfg_d.lanes = reg_wdata[FIELD_LSB +: LANES_W];
      end else if (sel_parm_a) begin
        cfg_d.parm_a = reg_wdata[FIELD_LSB +: PARM_W];
      end else if (sel_parm_b) begin
        cfg_d.parm_b = reg_wdata[FIELD_LSB +: PARM_W];
      end
    end
  end

  // link field storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= CFG_RST;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // read data sees fields as they stand before this cycle's write
  always_comb begin
    rdata_d = 8'h00;
    if (sel_quick) begin
      rdata_d = QUICK_READBACK;
    end else if (sel_mode) begin
      rdata_d = 8'(cfg_q.mode);
    end else if (sel_lanes) begin
      rdata_d = 8'(cfg_q.lanes);
    end else if (sel_parm_a) begin
      rdata_d = 8'(cfg_q.parm_a);
    end else if (sel_parm_b) begin
      rdata_d = 8'(cfg_q.parm_b);
    end
  end

  // read data held until the next read so a slow port can sample it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= QUICK_SETUP_RST;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign link_cfg  = cfg_q;

  // checks
  a_quick_reads_zero: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick) ##1 (reg_rd && sel_quick) |=> (reg_rdata == 8'h00)
  ) else $error("quick setup readback not zero after write");

  a_fields_only_write: assert property (
    @(posedge clk) disable iff (rst)
    !reg_wr |=> (link_cfg == $past(link_cfg))
  ) else $error("link fields changed without a register write");

  a_keep_code_hold: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick && reg_wdata == 8'h00) |=> $stable(link_cfg)
  ) else $error("code zero altered link fields");

  a_two_lane_load: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick && reg_wdata == 8'h02) |=>
      (link_cfg.mode == 4'h0 && link_cfg.lanes == 5'h01 && link_cfg.parm_a == 5'h0b && link_cfg.parm_b == 5'h0f)
  ) else $error("two-lane preset wrong");

  a_four_lane_load: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick && reg_wdata == 8'h04) |=>
      (link_cfg.mode == 4'h0 && link_cfg.lanes == 5'h03 && link_cfg.parm_a == 5'h0b && link_cfg.parm_b == 5'h0f)
  ) else $error("four-lane preset wrong");

  a_six_lane_load: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick && reg_wdata == 8'h06) |=>
      (link_cfg.mode == 4'h0 && link_cfg.lanes == 5'h05 && link_cfg.parm_a == 5'h0b && link_cfg.parm_b == 5'h0b)
  ) else $error("six-lane preset wrong");

  a_eight_lane_load: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick && reg_wdata == 8'h08) |=>
      (link_cfg.mode == 4'h0 && link_cfg.lanes == 5'h07 && link_cfg.parm_a == 5'h0b && link_cfg.parm_b == 5'h0f)
  ) else $error("eight-lane preset wrong");

  a_unknown_code_hold: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick && !(reg_wdata inside {8'h02, 8'h04, 8'h06, 8'h08})) |=> $stable(link_cfg)
  ) else $error("undefined code altered link fields");

  a_reserved_code_hold: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick && reg_wdata == 8'h01) ##1 (!reg_wr && reg_rd && sel_quick) |=>
      ($stable(link_cfg) && reg_rdata == 8'h00)
  ) else $error("reserved code had an effect");

  a_preset_next_read: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick && reg_wdata == 8'h04) ##1 (!reg_wr && reg_rd && sel_lanes) |=> (reg_rdata == 8'h03)
  ) else $error("lane count not visible on the next access");

  // read-path and reserved-code checks: a preset must show through the port, not only on link_cfg
  a_quick_read_any: assert property (
    @(posedge clk) disable iff (rst)
    (reg_rd && sel_quick) |=> (reg_rdata == 8'h00)
  ) else $error("quick setup read returned nonzero");

  a_quick_no_rdata: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick && !reg_rd) |=> $stable(reg_rdata)
  ) else $error("quick setup write disturbed read data");

  a_keep_code_quiet: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick && reg_wdata == 8'h00 && !reg_rd) |=>
      ($stable(link_cfg) && $stable(reg_rdata))
  ) else $error("code zero had a visible effect");

  a_reserved_no_load: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick && reg_wdata == 8'h01) |=> $stable(link_cfg)
  ) else $error("reserved code loaded link fields");

  a_two_lane_read: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick && reg_wdata == 8'h02) ##1 (!reg_wr && reg_rd && sel_parm_b) |=>
      (reg_rdata == 8'h0f)
  ) else $error("two-lane preset not readable");

  a_four_lane_read: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick && reg_wdata == 8'h04) ##1 (!reg_wr && reg_rd && sel_parm_b) |=>
      (reg_rdata == 8'h0f)
  ) else $error("four-lane preset not readable");

  a_six_lane_read: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick && reg_wdata == 8'h06) ##1 (!reg_wr && reg_rd && sel_parm_b) |=>
      (reg_rdata == 8'h0b)
  ) else $error("six-lane preset not readable");

  a_eight_lane_read: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && sel_quick && reg_wdata == 8'h08) ##1 (!reg_wr && reg_rd && sel_parm_b) |=>
      (reg_rdata == 8'h0f)
  ) else $error("eight-lane preset not readable");

endmodule

// ---- slqs_pkg.sv ----
// shared constants and types for the serial link quick setup block
package slqs_pkg;

  // register-port geometry
  localparam int unsigned ADDR_W_DEF = 13;
  localparam int unsigned DATA_W     = 8;

  // register offsets
  localparam logic [12:0] OFS_QUICK_SETUP = 13'h05e;
  localparam logic [12:0] OFS_LINK_MODE   = 13'h063;
  localparam logic [12:0] OFS_LANE_COUNT  = 13'h06e;
  localparam logic [12:0] OFS_LINK_PARM_A = 13'h072;
  localparam logic [12:0] OFS_LINK_PARM_B = 13'h073;

  // field widths, all fields sit at bit 0
  localparam int unsigned MODE_W  = 4;
  localparam int unsigned LANES_W = 5;
  localparam int unsigned PARM_W  = 5;
  localparam int unsigned FIELD_LSB = 0;

  // reset and readback values
  localparam logic [7:0] QUICK_SETUP_RST = 8'h00;
  localparam logic [7:0] QUICK_READBACK  = 8'h00;

  // quick setup codes
  localparam logic [7:0] CODE_KEEP     = 8'h00;
  localparam logic [7:0] CODE_RESERVED = 8'h01;
  localparam logic [7:0] CODE_LANES2   = 8'h02;
  localparam logic [7:0] CODE_LANES4   = 8'h04;
  localparam logic [7:0] CODE_LANES6   = 8'h06;
  localparam logic [7:0] CODE_LANES8   = 8'h08;

  // preset field values
  localparam logic [3:0] PRE_MODE_GENERIC = 4'h0;
  localparam logic [4:0] PRE_LANES2       = 5'h01;
  localparam logic [4:0] PRE_LANES4       = 5'h03;
  localparam logic [4:0] PRE_LANES6       = 5'h05;
  localparam logic [4:0] PRE_LANES8       = 5'h07;
  localparam logic [4:0] PRE_PARM_B       = 5'h0b;
  localparam logic [4:0] PRE_PARM_F       = 5'h0f;

  // link control fields overwritten by a preset
  typedef struct packed {
    logic [MODE_W-1:0]  mode;
    logic [LANES_W-1:0] lanes;
    logic [PARM_W-1:0]  parm_a;
    logic [PARM_W-1:0]  parm_b;
  } slqs_cfg_t;

  localparam slqs_cfg_t CFG_RST = '{mode: 4'h0, lanes: 5'h00, parm_a: 5'h00, parm_b: 5'h00};

endpackage

// ---- slqs_preset.sv ----
// lookup of quick setup code to preset link field values
`timescale 1ns/1ps
module slqs_preset
  import slqs_pkg::*;
(
  input  wire logic [7:0]          code,
  output logic                     hit,
  output slqs_pkg::slqs_cfg_t      cfg
);

  always_comb begin
    hit = 1'b1;
    cfg = CFG_RST;
    case (code)
      CODE_LANES2: begin
        cfg = '{mode: PRE_MODE_GENERIC, lanes: PRE_LANES2, parm_a: PRE_PARM_B, parm_b: PRE_PARM_F};
      end
      CODE_LANES4: begin
        cfg = '{mode: PRE_MODE_GENERIC, lanes: PRE_LANES4, parm_a: PRE_PARM_B, parm_b: PRE_PARM_F};
      end
      CODE_LANES6: begin
        // six lanes is the one preset with both parameters at 0xb
        cfg = '{mode: PRE_MODE_GENERIC, lanes: PRE_LANES6, parm_a: PRE_PARM_B, parm_b: PRE_PARM_B};
      end
      CODE_LANES8: begin
        cfg = '{mode: PRE_MODE_GENERIC, lanes: PRE_LANES8, parm_a: PRE_PARM_B, parm_b: PRE_PARM_F};
      end
      // keep, reserved and all other codes load nothing
      default: begin
        hit = 1'b0;
      end
    endcase
  end

endmodule

// ---- slqs_top_tb.sv ----
// self-checking bench for the serial link quick setup block
`timescale 1ns/1ps
module slqs_top_tb;
  import slqs_pkg::*;
  logic        clk;
  logic        rst;
  logic        reg_wr;
  logic        reg_rd;
  logic [12:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  slqs_cfg_t   link_cfg;
  slqs_cfg_t   model;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cycles = 0;
  integer      seed;
  logic [12:0] amap [5] = '{13'h05e, 13'h063, 13'h06e, 13'h072, 13'h073};
  logic [7:0]  codes [8] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h00, 8'h01, 8'h03, 8'hff};

  slqs_top #(.ADDR_W(13)) dut (
    .clk       (clk),
    .rst       (rst),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata),
    .link_cfg  (link_cfg)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ceiling far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // expected link fields after a write; literals kept apart from the design's constants
  function automatic slqs_cfg_t exp_wr(slqs_cfg_t c, logic [12:0] a, logic [7:0] d);
    slqs_cfg_t r;
    r = c;
    case (a)
      13'h05e: case (d)
        8'h02: r = '{mode: 4'h0, lanes: 5'h01, parm_a: 5'h0b, parm_b: 5'h0f};
        8'h04: r = '{mode: 4'h0, lanes: 5'h03, parm_a: 5'h0b, parm_b: 5'h0f};
        8'h06: r = '{mode: 4'h0, lanes: 5'h05, parm_a: 5'h0b, parm_b: 5'h0b};
        8'h08: r = '{mode: 4'h0, lanes: 5'h07, parm_a: 5'h0b, parm_b: 5'h0f};
        default: r = c;
      endcase
      13'h063: r.mode = d[3:0];
      13'h06e: r.lanes = d[4:0];
      13'h072: r.parm_a = d[4:0];
      13'h073: r.parm_b = d[4:0];
      default: r = c;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] exp_rd(slqs_cfg_t c, logic [12:0] a);
    case (a)
      13'h063: return {4'h0, c.mode};
      13'h06e: return {3'h0, c.lanes};
      13'h072: return {3'h0, c.parm_a};
      13'h073: return {3'h0, c.parm_b};
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk_cfg(slqs_cfg_t e);
    tests_run++;
    if (link_cfg !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, link_cfg, e);
    end
  endtask

  task automatic chk_byte(logic [7:0] e);
    tests_run++;
    if (reg_rdata !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, reg_rdata, e);
    end
  endtask

  // strobes stay high across back-to-back calls
  task automatic wr(logic [12:0] a, logic [7:0] d);
    reg_wr = 1'b1;
    reg_rd = 1'b0;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    model = exp_wr(model, a, d);
  endtask

  task automatic rd(logic [12:0] a);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    int idx;
    logic [12:0] a;
    logic [7:0] d;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 13'h0000;
    reg_wdata = 8'h00;
    seed = 32'hf533;
    model = '0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_cfg(model);
    chk_byte(8'h00);
    for (int i = 0; i < 8; i++) begin
      for (int j = 1; j < 5; j++) wr(amap[j], (i < 4) ? 8'hff : 8'($random(seed)));
      wr(13'h05e, codes[i]);
      chk_cfg(model);
      for (int j = 4; j >= 0; j--) begin
        rd(amap[j]);
        chk_byte(exp_rd(model, amap[j]));
      end
    end
    // preset, a tweak of one field, then the reserved code; each read follows its write at once
    wr(13'h05e, 8'h04);
    rd(13'h06e);
    chk_byte(exp_rd(model, 13'h06e));
    wr(13'h06e, 8'h02);
    chk_cfg(model);
    wr(13'h05e, 8'h01);
    rd(13'h05e);
    chk_byte(8'h00);
    chk_cfg(model);
    for (int i = 0; i < 400; i++) begin
      idx = $unsigned($random(seed)) % 6;
      a = (idx < 5) ? amap[idx] : 13'($random(seed));
      d = 8'($random(seed));
      if (idx == 0 && d[7]) d = {4'h0, d[3:0]};
      if (d[6] ^ d[0]) begin
        wr(a, d);
        chk_cfg(model);
      end else begin
        rd(a);
        chk_byte(exp_rd(model, a));
      end
    end
    // reset again in mid-run after a preset
    wr(13'h05e, 8'h06);
    chk_cfg(model);
    rst = 1'b1;
    reg_wr = 1'b0;
    @(negedge clk);
    model = '0;
    chk_cfg(model);
    chk_byte(8'h00);
    rst = 1'b0;
    @(negedge clk);
    chk_cfg(model);
    wr(13'h05e, 8'h08);
    chk_cfg(model);
    complete_run();
  end
endmodule
